// File: tlic_pkg.sv
// shared constants and types of the two-level interrupt controller
package tlic_pkg;

  // ---------------------------------------------------------------
  // source layout
  // ---------------------------------------------------------------
  localparam int NSRC = 14;
  localparam int IDW = 4;
  localparam int PRI_SRCS = 7;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int REGW = 8;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PEN = 8'h00;
  localparam logic [7:0] ADDR_XEN = 8'h04;
  localparam logic [7:0] ADDR_PPRI = 8'h08;
  localparam logic [7:0] ADDR_XPRI = 8'h0c;
  localparam logic [7:0] ADDR_PEND = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [1:0] ADDR_ALIGN = 2'h0;

  // ---------------------------------------------------------------
  // reset values and fixed behaviour
  // ---------------------------------------------------------------
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [13:0] PEND_RST = 14'h0000;
  localparam logic [13:0] AUTOCLR_MASK = 14'h000f;
  localparam logic [13:0] ONE_SRC = 14'h0001;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int STAT_LOW_BIT = 0;
  localparam int STAT_HIGH_BIT = 1;
  localparam int STAT_REQ_BIT = 2;
  localparam int STAT_HOLD_BIT = 3;
  localparam int STAT_ID_LSB = 4;

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // routines in service
  typedef enum logic [1:0] {SVC_IDLE, SVC_LOW, SVC_HIGH, SVC_NESTED} tlic_svc_e;

endpackage : tlic_pkg

// File: tlic_pending.sv
// pending flags, one per source
`timescale 1ns/10ps
module tlic_pending (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] src_event,
  input wire logic sw_wr,
  input wire logic [13:0] sw_mask,
  input wire logic [13:0] sw_data,
  input wire logic [13:0] hw_clr,
  output logic [13:0] pend
);

  logic [13:0] pend_ff;
  logic [13:0] nxt_pend;

  // per flag: event sets over any clear, software writes, vectoring clears
  for (genvar i = 0; i < tlic_pkg::NSRC; i++) begin : g_flag
    always_comb begin
      if (src_event[i]) begin
        nxt_pend[i] = 1'b1; // [R2]
      end else if (sw_wr && sw_mask[i]) begin
        nxt_pend[i] = sw_data[i]; // [R13]
      end else begin
        nxt_pend[i] = pend_ff[i] & ~hw_clr[i]; // [R11]
      end
    end
  end

  // flag registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_ff <= tlic_pkg::PEND_RST;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  assign pend = pend_ff;

endmodule : tlic_pending

// File: tlic_arbiter.sv
// level then fixed-order arbiter over the active sources
`timescale 1ns/10ps
module tlic_arbiter (
  input wire logic [13:0] active,
  input wire logic [13:0] prio,
  output logic found,
  output logic [3:0] win_id,
  output logic win_high
);

  logic any_high;

  // high level beats low, then the lowest index wins
  always_comb begin
    any_high = |(active & prio); // [R16]
    found = |active;
    win_high = any_high;
    win_id = '0;
    for (int i = tlic_pkg::NSRC - 1; i >= 0; i--) begin
      if (active[i] && (prio[i] == any_high)) begin
        win_id = i[3:0]; // [R17] [R21]
      end
    end
  end

endmodule : tlic_arbiter

// File: tlic_top.sv
// two-level interrupt controller with axi4-lite register access
//
// How it works
// [R1] fourteen sources, each placed at low or high level
// [R2] a source event sets its pending flag regardless of its enable
// [R3] enabled pending flag raises a request; core calls its fixed vector
// [R4] core resumes the interrupted flow on return; controller unwinds service
// [R5] pending flags of disabled sources never raise a request
// [R6] per-source enables count only while the global enable bit is one
// [R7] global enable at zero blocks every source
// [R8] enable cleared: request drops one cycle later, may slip once
// [R9] enable reads show the new value at once, even inside a routine
// [R10] software should follow an enable clear with a two-byte instruction
// [R11] some flags clear on vectoring, the rest wait for software
// [R12] flag still set after return re-raises after one more instruction
// [R13] software writing a one to a flag acts as a hardware event
// [R14] each source has a level bit, all low after reset
// [R15] high preempts low routines; high routines are never preempted
// [R16] of simultaneous requests the high-level one goes first
// [R17] same level requests resolved by a fixed per-source order
// [R18] requests sampled every cycle, request one cycle after the flag
// [R19] after a return exactly one instruction runs before the next call
// [R20] equal or lower level waits for routine, return and one instruction
// [R21] distinct vector per source; lower index wins within a level
`timescale 1ns/10ps
module tlic_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [13:0] src_event,
  input wire logic instr_done,
  input wire logic irq_ack,
  input wire logic return_from_interrupt_done,
  output logic irq_req,
  output logic irq_high,
  output logic [3:0] irq_id,
  output logic [15:0] irq_vector
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic aw_hold_ff, nxt_aw_hold;
  logic w_hold_ff, nxt_w_hold;
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0] pen_ff, nxt_pen;
  logic [7:0] xen_ff, nxt_xen;
  logic [7:0] ppri_ff, nxt_ppri;
  logic [7:0] xpri_ff, nxt_xpri;
  tlic_pkg::tlic_svc_e svc_ff, nxt_svc;
  logic hold_ff, nxt_hold;
  logic req_ff, nxt_req;
  logic high_ff, nxt_high;
  logic [3:0] id_ff, nxt_id;
  logic [15:0] vec_ff, nxt_vec;
  logic do_write;
  logic do_read;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [7:0] lane0;
  logic sw_wr;
  logic [13:0] sw_mask;
  logic [13:0] hw_clr;
  logic [13:0] pend;
  logic [13:0] en14;
  logic [13:0] pri14;
  logic [13:0] active;
  logic found;
  logic [3:0] win_id;
  logic win_high;
  logic allow;
  logic low_in;
  logic high_in;

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_addr = {aw_addr_ff[7:2], tlic_pkg::ADDR_ALIGN};
  assign lane0 = w_strb_ff[0] ? w_data_ff[7:0] : 8'h00;

  // address and data are caught in either order, answer follows both
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_hold = w_hold_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_hold = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      case (wr_addr)
        tlic_pkg::ADDR_PEN, tlic_pkg::ADDR_XEN, tlic_pkg::ADDR_PPRI,
        tlic_pkg::ADDR_XPRI, tlic_pkg::ADDR_PEND, tlic_pkg::ADDR_STAT: begin
          nxt_bresp = tlic_pkg::RESP_OKAY;
        end
        default: begin
          nxt_bresp = tlic_pkg::RESP_SLVERR;
        end
      endcase
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= tlic_pkg::RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_hold_ff <= nxt_w_hold;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ---------------------------------------------------------------
  // enable and level registers
  // ---------------------------------------------------------------
  // byte lane 0 only; new values are visible on the next read at once
  always_comb begin
    nxt_pen = pen_ff;
    nxt_xen = xen_ff;
    nxt_ppri = ppri_ff;
    nxt_xpri = xpri_ff;
    if (do_write && w_strb_ff[0]) begin
      case (wr_addr)
        tlic_pkg::ADDR_PEN: nxt_pen = lane0; // [R9]
        tlic_pkg::ADDR_XEN: nxt_xen = lane0;
        tlic_pkg::ADDR_PPRI: nxt_ppri = lane0;
        tlic_pkg::ADDR_XPRI: nxt_xpri = lane0;
        default: nxt_pen = pen_ff;
      endcase
    end
  end

  // control registers, all levels low after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pen_ff <= tlic_pkg::ENABLE_RST;
      xen_ff <= tlic_pkg::ENABLE_RST;
      ppri_ff <= tlic_pkg::PRIO_RST; // [R14]
      xpri_ff <= tlic_pkg::PRIO_RST;
    end else begin
      pen_ff <= nxt_pen;
      xen_ff <= nxt_xen;
      ppri_ff <= nxt_ppri;
      xpri_ff <= nxt_xpri;
    end
  end

  // ---------------------------------------------------------------
  // pending flags and arbitration
  // ---------------------------------------------------------------
  assign sw_wr = do_write && (wr_addr == tlic_pkg::ADDR_PEND); // [R13]
  assign sw_mask = {{6{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  assign hw_clr = irq_ack ? (tlic_pkg::AUTOCLR_MASK & (tlic_pkg::ONE_SRC << id_ff)) :
                  tlic_pkg::PEND_RST; // [R11]
  assign en14 = {xen_ff[tlic_pkg::PRI_SRCS-1:0], pen_ff[tlic_pkg::PRI_SRCS-1:0]};
  assign pri14 = {xpri_ff[tlic_pkg::PRI_SRCS-1:0], ppri_ff[tlic_pkg::PRI_SRCS-1:0]}; // [R1]
  // global bit gates every individual enable
  assign active = pend & en14 & {tlic_pkg::NSRC{pen_ff[tlic_pkg::GLOBAL_EN_BIT]}}; // [R5] [R6] [R7]

  tlic_pending u_pending (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_event(src_event),
    .sw_wr(sw_wr),
    .sw_mask(sw_mask),
    .sw_data(w_data_ff[13:0]),
    .hw_clr(hw_clr),
    .pend(pend)
  );

  tlic_arbiter u_arbiter (
    .active(active),
    .prio(pri14),
    .found(found),
    .win_id(win_id),
    .win_high(win_high)
  );

  // ---------------------------------------------------------------
  // service tracking and request
  // ---------------------------------------------------------------
  assign low_in = (svc_ff == tlic_pkg::SVC_LOW) || (svc_ff == tlic_pkg::SVC_NESTED);
  assign high_in = (svc_ff == tlic_pkg::SVC_HIGH) || (svc_ff == tlic_pkg::SVC_NESTED);
  // only high may enter a low routine, nothing enters a high one
  assign allow = !hold_ff && ((svc_ff == tlic_pkg::SVC_IDLE) ||
                 ((svc_ff == tlic_pkg::SVC_LOW) && win_high)); // [R15] [R20]

  // call pushes a level, return pops it and holds off for one instruction
  always_comb begin
    nxt_svc = svc_ff;
    nxt_hold = hold_ff;
    if (irq_ack) begin
      case (svc_ff)
        tlic_pkg::SVC_IDLE: nxt_svc = high_ff ? tlic_pkg::SVC_HIGH : tlic_pkg::SVC_LOW; // [R3]
        tlic_pkg::SVC_LOW: nxt_svc = tlic_pkg::SVC_NESTED; // [R15]
        default: nxt_svc = svc_ff;
      endcase
    end else if (return_from_interrupt_done) begin
      nxt_hold = 1'b1; // [R12] [R19]
      case (svc_ff)
        tlic_pkg::SVC_NESTED: nxt_svc = tlic_pkg::SVC_LOW; // [R4]
        default: nxt_svc = tlic_pkg::SVC_IDLE;
      endcase
    end else if (instr_done) begin
      nxt_hold = 1'b0; // [R19]
    end
  end

  // registered request, one cycle behind the flags
  always_comb begin
    nxt_req = found && allow && !irq_ack && !return_from_interrupt_done; // [R3] [R18]
    nxt_high = win_high;
    nxt_id = win_id;
    nxt_vec = tlic_pkg::VEC_BASE + (tlic_pkg::VEC_STEP * {12'h000, win_id}); // [R21]
    if (!nxt_req) begin
      nxt_high = high_ff;
      nxt_id = id_ff;
      nxt_vec = vec_ff;
    end
  end

  // service and request registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      svc_ff <= tlic_pkg::SVC_IDLE;
      hold_ff <= 1'b0;
      req_ff <= 1'b0;
      high_ff <= 1'b0;
      id_ff <= 4'h0;
      vec_ff <= tlic_pkg::VEC_BASE;
    end else begin
      svc_ff <= nxt_svc;
      hold_ff <= nxt_hold;
      req_ff <= nxt_req; // [R8]
      high_ff <= nxt_high;
      id_ff <= nxt_id;
      vec_ff <= nxt_vec;
    end
  end

  assign irq_req = req_ff;
  assign irq_high = high_ff;
  assign irq_id = id_ff;
  assign irq_vector = vec_ff;

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign do_read = s_axi_arvalid && !rvalid_ff;
  assign rd_addr = {s_axi_araddr[7:2], tlic_pkg::ADDR_ALIGN};

  // read mux, one cycle to the answer
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (do_read) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = tlic_pkg::RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      case (rd_addr)
        tlic_pkg::ADDR_PEN: nxt_rdata[7:0] = pen_ff; // [R9]
        tlic_pkg::ADDR_XEN: nxt_rdata[7:0] = xen_ff;
        tlic_pkg::ADDR_PPRI: nxt_rdata[7:0] = ppri_ff;
        tlic_pkg::ADDR_XPRI: nxt_rdata[7:0] = xpri_ff;
        tlic_pkg::ADDR_PEND: nxt_rdata[13:0] = pend;
        tlic_pkg::ADDR_STAT: begin
          nxt_rdata[tlic_pkg::STAT_LOW_BIT] = low_in;
          nxt_rdata[tlic_pkg::STAT_HIGH_BIT] = high_in;
          nxt_rdata[tlic_pkg::STAT_REQ_BIT] = req_ff;
          nxt_rdata[tlic_pkg::STAT_HOLD_BIT] = hold_ff;
          nxt_rdata[tlic_pkg::STAT_ID_LSB +: tlic_pkg::IDW] = id_ff;
        end
        default: nxt_rresp = tlic_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= tlic_pkg::RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_global_blocks: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    !pen_ff[tlic_pkg::GLOBAL_EN_BIT] |=> !req_ff)
    else $error("request raised with global enable off");

  a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    ((pend & en14) == tlic_pkg::PEND_RST) |=> !req_ff)
    else $error("request raised without an enabled pending flag");

  a_event_sets: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    |src_event |=> ((pend & $past(src_event)) == $past(src_event)))
    else $error("source event did not set its flag");

  a_request_latency: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
    (found && allow && !irq_ack && !return_from_interrupt_done) |=> req_ff && (id_ff == $past(win_id)))
    else $error("request not raised one cycle after arbitration");

  a_high_not_preempted: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
    (high_in && $past(high_in)) |-> !req_ff)
    else $error("request raised inside a high routine");

  a_return_holdoff: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
    (return_from_interrupt_done && !irq_ack) |=> !req_ff [*2])
    else $error("request raised before one instruction after return");

  a_auto_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    (irq_ack && tlic_pkg::AUTOCLR_MASK[id_ff] && !src_event[id_ff] && !sw_wr)
    |=> !pend[$past(id_ff)])
    else $error("auto-cleared flag stayed set after vectoring");

  a_level_default: assert property (@(posedge aclk) // [R14]
    !aresetn |=> (pri14 == tlic_pkg::PEND_RST))
    else $error("level bits not low after reset");

  a_soft_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    sw_wr |=> ((pend & $past(sw_mask & w_data_ff[13:0])) == $past(sw_mask & w_data_ff[13:0])))
    else $error("software write of one did not set the flag");

  a_high_first: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
    (found && allow && |(active & pri14) && !irq_ack && !return_from_interrupt_done) |=> high_ff)
    else $error("low request chosen over a high one");

endmodule : tlic_top

// File: tlic_core_model.sv
// behavioural core model that takes calls and returns from routines
`timescale 1ns/10ps
module tlic_core_model #(
  parameter int RUN_LEN = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_req,
  input wire logic ack_en,
  input wire logic [3:0] ack_dly,
  output logic irq_ack,
  output logic instr_done,
  output logic return_from_interrupt_done
);
  int wait_ff;
  int run_ff;
  int depth_ff;
  int tick_ff;
  logic ready_ff;

  // a call is taken only in a cycle where the request stands
  assign irq_ack = irq_req && ready_ff && !return_from_interrupt_done;

  // instruction stream, call delay and nested routine lengths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_ff <= 0;
      run_ff <= 0;
      depth_ff <= 0;
      tick_ff <= 0;
      ready_ff <= 1'b0;
      instr_done <= 1'b0;
      return_from_interrupt_done <= 1'b0;
    end else begin
      tick_ff <= (tick_ff == 2) ? 0 : tick_ff + 1;
      instr_done <= (tick_ff == 2); // one instruction ends the post-return wait
      return_from_interrupt_done <= 1'b0;
      wait_ff <= (irq_req && ack_en && !irq_ack) ? wait_ff + 1 : 0;
      ready_ff <= irq_req && ack_en && !irq_ack && (wait_ff >= int'(ack_dly));
      if (irq_ack) begin
        depth_ff <= depth_ff + 1;
        run_ff <= RUN_LEN;
      end else if (depth_ff > 0) begin
        if (run_ff == 0) begin
          return_from_interrupt_done <= 1'b1; // one return per taken call
          depth_ff <= depth_ff - 1;
          run_ff <= RUN_LEN;
        end else begin
          run_ff <= run_ff - 1;
        end
      end
    end
  end
endmodule : tlic_core_model

// File: tb_top.sv
// self-checking bench for the two-level interrupt controller
`timescale 1ns/10ps
module tb_top;
  localparam int RUN = 40;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf, ack_dly = 4'h0, irq_id;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [13:0] src_event = 14'h0;
  logic instr_done, irq_ack, return_from_interrupt_done, irq_req, irq_high, ack_en = 1'b1;
  logic [15:0] irq_vector;
  logic [33:0] q_rd[$];
  logic [33:0] q_b[$];
  logic [20:0] q_irq[$];
  int fail_count = 0, cmp_count = 0;

  tlic_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .src_event, .instr_done, .irq_ack, .return_from_interrupt_done, .irq_req, .irq_high,
    .irq_id, .irq_vector);
  tlic_core_model #(.RUN_LEN(RUN)) core (.aclk, .aresetn, .irq_req, .ack_en, .ack_dly,
    .irq_ack, .instr_done, .return_from_interrupt_done);

  // clock
  always #5 aclk = ~aclk;

  // ----------------------------------------------------------------
  // compare tasks
  // ----------------------------------------------------------------
  task automatic chk_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk_bus

  task automatic chk_irq(input logic [20:0] e, input logic [20:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected call: expected %h seen %h", e, g);
    end
  endtask : chk_irq

  task automatic chk_lvl(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask : chk_lvl

  // result watcher: oldest note against each result
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk_bus("read", q_rd.size() ? q_rd.pop_front() : 'x, {s_axi_rresp, s_axi_rdata});
    end
    if (s_axi_bvalid && s_axi_bready) begin
      chk_bus("bresp", q_b.size() ? q_b.pop_front() : 'x, {32'h0, s_axi_bresp});
    end
    if (irq_ack) begin
      chk_irq(q_irq.size() ? q_irq.pop_front() : 'x, {irq_high, irq_id, irq_vector});
    end
  end

  // ----------------------------------------------------------------
  // bus and core tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = tlic_pkg::RESP_OKAY);
    logic ta, tw, tb;
    q_b.push_back({32'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    // one idle edge so a following call never re-raises bready in the same step
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = tlic_pkg::RESP_OKAY);
    logic ta, tr;
    q_rd.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    // one idle edge so a following call never re-raises rready in the same step
    @(posedge aclk);
  endtask : rd

  task automatic exp_irq(input int i, input logic hi);
    q_irq.push_back({hi, 4'(i), tlic_pkg::VEC_BASE + tlic_pkg::VEC_STEP * 16'(i)});
  endtask : exp_irq

  task automatic pulse(input int i, input logic lat);
    src_event <= 14'h1 << i;
    @(posedge aclk);
    src_event <= 14'h0;
    if (lat) begin
      @(negedge aclk);
      chk_lvl("early request", 1'b0, irq_req);
      @(negedge aclk);
      chk_lvl("request", 1'b1, irq_req);
      @(posedge aclk);
    end
  endtask : pulse

  task automatic wait_ack();
    do @(negedge aclk); while (irq_ack !== 1'b1);
    @(posedge aclk);
  endtask : wait_ack

  task automatic end_sim();
    if (q_rd.size() + q_b.size() + q_irq.size() != 0) fail_count++;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    void'($urandom(26307));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int k = 0; k < 6; k++) rd(8'(4 * k), 32'h0);
    rd(8'h18, 32'h0, tlic_pkg::RESP_SLVERR);
    wr(8'h18, 32'hff, tlic_pkg::RESP_SLVERR);
    wr(tlic_pkg::ADDR_STAT, 32'hff);
    rd(tlic_pkg::ADDR_STAT, 32'h0);
    d = $urandom;
    wr(tlic_pkg::ADDR_XPRI, {24'h0, d[7:0]});
    rd(tlic_pkg::ADDR_XPRI, {24'h0, d[7:0]});
    wr(tlic_pkg::ADDR_XPRI, 32'h0);
    // flags set while every source is masked
    wr(tlic_pkg::ADDR_PEN, 32'h80);
    src_event <= d[21:8];
    @(posedge aclk);
    src_event <= 14'h0;
    repeat (4) @(posedge aclk);
    rd(tlic_pkg::ADDR_PEND, {18'h0, d[21:8]});
    rd(tlic_pkg::ADDR_STAT, 32'h0);
    wr(tlic_pkg::ADDR_PEND, 32'h0);
    // every source in turn
    wr(tlic_pkg::ADDR_PEN, 32'hff);
    wr(tlic_pkg::ADDR_XEN, 32'h7f);
    for (int i = 0; i < 14; i++) begin
      ack_dly <= 4'($urandom_range(7));
      exp_irq(i, 1'b0);
      pulse(i, 1'b1);
      wait_ack();
      rd(tlic_pkg::ADDR_PEND, i < 4 ? 32'h0 : 32'h1 << i);
      if (i == 5) begin
        exp_irq(5, 1'b0);
        wait_ack();
      end
      if (i >= 4) wr(tlic_pkg::ADDR_PEND, 32'h0);
      repeat (RUN + 20) @(posedge aclk);
    end
    // global enable off, clear repeated
    wr(tlic_pkg::ADDR_PEN, 32'h7f);
    wr(tlic_pkg::ADDR_PEN, 32'h7f);
    rd(tlic_pkg::ADDR_PEN, 32'h7f);
    pulse(2, 1'b0);
    repeat (5) @(posedge aclk);
    rd(tlic_pkg::ADDR_STAT, 32'hd0);
    rd(tlic_pkg::ADDR_PEND, 32'h4);
    exp_irq(2, 1'b0);
    wr(tlic_pkg::ADDR_PEN, 32'hff);
    wait_ack();
    repeat (RUN + 20) @(posedge aclk);
    // levels, order and preemption
    ack_en <= 1'b0;
    wr(tlic_pkg::ADDR_PPRI, 32'h0c);
    wr(tlic_pkg::ADDR_PEND, 32'h0b);
    exp_irq(3, 1'b1);
    exp_irq(0, 1'b0);
    ack_en <= 1'b1;
    wait_ack();
    wait_ack();
    exp_irq(2, 1'b1);
    exp_irq(1, 1'b0);
    pulse(2, 1'b0);
    wait_ack();
    rd(tlic_pkg::ADDR_STAT, 32'h23);
    wait_ack();
    repeat (3 * RUN) @(posedge aclk);
    end_sim();
  end
endmodule : tb_top
